// ===== mcs_pkg.sv
// constants and types shared by both ends of the master control/status register port
`default_nettype none
package mcs_pkg;
    // -------------------------------------------------------------------------
    // port geometry
    // -------------------------------------------------------------------------
    localparam int unsigned ADDR_W        = 11;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned NUM_CHAN      = 4;
    localparam int unsigned NUM_MON       = 8;
    localparam int unsigned SYS_ADDR_W    = 5;
    // -------------------------------------------------------------------------
    // register offsets (channel n reset/update sits at OFS_CRU + (n-1)*0x100)
    // -------------------------------------------------------------------------
    localparam logic [10:0] OFS_MRI       = 11'h000;
    localparam logic [10:0] OFS_SIF       = 11'h002;
    localparam logic [10:0] OFS_CKM       = 11'h003;
    localparam logic [10:0] OFS_MIS       = 11'h004;
    localparam logic [7:0]  OFS_CRU       = 8'h05;
    localparam logic [7:0]  GLOB_LAST     = 8'h04;
    // -------------------------------------------------------------------------
    // field positions, masks and reset values
    // -------------------------------------------------------------------------
    localparam int unsigned SIF_MODE_BIT  = 0;
    localparam int unsigned SIF_PLVL_BIT  = 1;
    localparam int unsigned SIF_EN_BIT    = 4;
    localparam int unsigned SIF_ADR_LSB   = 5;
    localparam logic [7:0]  SIF_WMASK     = 8'hf7;
    localparam logic [7:0]  SIF_RST       = 8'h00;
    localparam int unsigned CKM_REF_BIT   = 0;
    localparam int unsigned CKM_TFF_BIT   = 1;
    localparam int unsigned CKM_RFF_BIT   = 2;
    localparam int unsigned CKM_TXO_BIT   = 3;
    localparam int unsigned CKM_RX1_BIT   = 4;
    localparam int unsigned MIS_CSU_BIT   = 4;
    localparam int unsigned CRU_RST_BIT   = 7;
    localparam int unsigned CRU_TIP_BIT   = 0;
    localparam logic [7:0]  CRU_WMASK     = 8'h80;
    localparam logic [3:0]  CHAN_RST_RST  = 4'hf;
    localparam logic [4:0]  NULL_ADDR     = 5'h1f;
    // -------------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned XFER_TIME_NS  = 200;
    localparam logic [3:0]  XFER_CYCLES   = 4'((XFER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int unsigned POLL_TIME_US  = 100;
    localparam logic [11:0] POLL_CYCLES   = 12'((POLL_TIME_US * 1000) / CLK_PERIOD_NS);
    // -------------------------------------------------------------------------
    // host sequencer states
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        H_IDLE   = 2'b00,
        H_STROBE = 2'b01,
        H_WAIT   = 2'b10
    } mcs_host_state_t;
endpackage
`default_nettype wire

// ===== mcs_reg_if.sv
// parallel register port joining the host end and the device end
`default_nettype none
interface mcs_reg_if;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic [10:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        rdata_oe;
    modport dev  (input cs_n, rd_n, wr_n, addr, wdata, output rdata, rdata_oe);
    modport host (output cs_n, rd_n, wr_n, addr, wdata, input rdata, rdata_oe);
endinterface
`default_nettype wire

// ===== mcs_dev_end.sv
// device end: global control/status registers and per-channel reset/update
//
// Overview of operation
// R01 - bit 0 selects cell or packet mode
// R02 - mode drives mapping and system-bus pin meaning
// R03 - bit 1 picks byte or packet transfer
// R04 - enable clear floats bus except packet-available
// R05 - host enables bus before any traffic
// R06 - host assigns unique addresses before enabling
// R07 - address field matches bus bits 4:2
// R08 - address 0x1F never selects a port
// R09 - rising edges set bits, read clears all
// R10 - fixed mapping of eight monitored clocks
// R11 - host polls activity bits periodically
// R12 - interrupt output low on active source
// R13 - summary shows channels and synthesis requests
// R14 - summary read acknowledges nothing
// R15 - plain write starts counter transfer, flag set
// R16 - host waits for flag low; the host end never reads the flag, done_o follows the write strobe
// R17 - soft-reset bit holds channel, hardware clears
// R18 - soft reset equals hardware reset per channel
// R19 - channel 1 reset blocks global registers
// R20 - host writes reserved bits as defaults
// R21 - edges captured and synchronised, none lost
`default_nettype none
module mcs_dev_end (
    // clock and reset
    input  wire logic                         mclk_i,
    input  wire logic                         rst_n_i,
    // register port
    mcs_reg_if.dev                            bus,
    // monitored clocks, bit order as the activity register
    input  wire logic [mcs_pkg::NUM_MON-1:0]  mon_clk_i,
    // interrupt requests from channels and clock synthesis
    input  wire logic [mcs_pkg::NUM_CHAN-1:0] chan_irq_i,
    input  wire logic                         synth_irq_i,
    // system-bus addresses from pins
    input  wire logic [4:0]                   tx_bus_addr_i,
    input  wire logic [4:0]                   rx_bus_addr_i,
    // mode and system-bus control
    output logic                              cell_packet_mode_sel_o,
    output logic                              packet_level_xfer_sel_o,
    output logic                              sys_bus_oe_o,
    output logic                              pkt_avail_oe_o,
    output logic                              tx_sel_o,
    output logic [1:0]                        tx_chan_o,
    output logic                              rx_sel_o,
    output logic [1:0]                        rx_chan_o,
    // interrupt
    output logic                              irq_out_n_o,
    // per-channel reset and counter transfer
    output logic [mcs_pkg::NUM_CHAN-1:0]      chan_reset_o,
    output logic [mcs_pkg::NUM_CHAN-1:0]      counter_latch_o,
    output logic [mcs_pkg::NUM_CHAN-1:0]      transfer_in_progress_o
);
    import mcs_pkg::*;

    // -------------------------------------------------------------------------
    // decode helpers
    // -------------------------------------------------------------------------
    // true for a channel reset/update access; address bits 9:8 then give the channel index
    function automatic logic is_cru(input logic [10:0] a);
        return (a[10] == 1'b0) && (a[7:0] == OFS_CRU);
    endfunction

    function automatic logic is_glob(input logic [10:0] a);
        return (a[10:8] == 3'h0) && (a[7:0] <= GLOB_LAST);
    endfunction

    // a system-bus address selects us when the top bits match and it is not null
    function automatic logic bus_hit(input logic [4:0] a, input logic [2:0] dev);
        return (a[4:2] == dev) && (a != NULL_ADDR);
    endfunction

    // -------------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------------
    logic [NUM_MON-1:0] mon_s1_q, mon_s2_q, mon_s3_q;
    logic [4:0]         txa_s1_q, txa_s2_q, rxa_s1_q, rxa_s2_q;
    logic [NUM_MON-1:0] mon_edge;

    // monitored clocks are sampled, so each must run below half of mclk
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            mon_s1_q <= '0;
            mon_s2_q <= '0;
            mon_s3_q <= '0;
            txa_s1_q <= NULL_ADDR;
            txa_s2_q <= NULL_ADDR;
            rxa_s1_q <= NULL_ADDR;
            rxa_s2_q <= NULL_ADDR;
        end else begin
            mon_s1_q <= mon_clk_i;                       // [R21]
            mon_s2_q <= mon_s1_q;
            mon_s3_q <= mon_s2_q;
            txa_s1_q <= tx_bus_addr_i;
            txa_s2_q <= txa_s1_q;
            rxa_s1_q <= rx_bus_addr_i;
            rxa_s2_q <= rxa_s1_q;
        end
    end

    // rising edge seen only after the second stage
    assign mon_edge = mon_s2_q & ~mon_s3_q;              // [R09] [R21]

    // -------------------------------------------------------------------------
    // register file
    // -------------------------------------------------------------------------
    logic [7:0]          sif_q, sif_d;
    logic [NUM_MON-1:0]  act_q, act_d;
    logic [NUM_CHAN-1:0] srst_q, srst_d;
    logic [3:0]          xcnt_q [NUM_CHAN];
    logic [3:0]          xcnt_d [NUM_CHAN];
    logic [NUM_CHAN-1:0] start_d;
    logic [7:0]          rdata_d;
    logic                wr_en, rd_en, glob_ok;
    logic [1:0]          acc_ch;

    assign wr_en   = !bus.cs_n && !bus.wr_n;
    assign rd_en   = !bus.cs_n && !bus.rd_n && bus.wr_n;
    assign acc_ch  = bus.addr[9:8];
    // global block closed while channel 1 sits in soft reset
    assign glob_ok = is_glob(bus.addr) && !srst_q[0];    // [R19]

    // next state for control, activity, reset and read data
    always_comb begin
        sif_d   = sif_q;
        srst_d  = srst_q;
        start_d = '0;
        rdata_d = 8'h00;
        // a new edge always survives a read in the same cycle
        act_d   = act_q | mon_edge;                      // [R09] [R21]
        if (wr_en && glob_ok && bus.addr == OFS_SIF) begin
            sif_d = bus.wdata & SIF_WMASK;               // [R01] [R03] [R04]
        end
        if (rd_en && glob_ok) begin
            case (bus.addr)
                OFS_SIF: rdata_d = sif_q;
                OFS_CKM: begin
                    rdata_d = act_q;                     // [R10]
                    act_d   = mon_edge;                  // [R09]
                end
                // live summary, reading it touches no source
                OFS_MIS: rdata_d = {3'h0, synth_irq_i, chan_irq_i}; // [R13] [R14]
                default: rdata_d = 8'h00;
            endcase
        end
        if (wr_en && is_cru(bus.addr)) begin
            srst_d[acc_ch] = bus.wdata[CRU_RST_BIT];     // [R17]
            start_d[acc_ch] = !bus.wdata[CRU_RST_BIT];   // [R15]
        end
        if (rd_en && is_cru(bus.addr)) begin
            rdata_d = 8'h00;
            rdata_d[CRU_RST_BIT] = srst_q[acc_ch];
            rdata_d[CRU_TIP_BIT] = (xcnt_q[acc_ch] != 4'h0);
        end
    end

    // transfer counters, one per channel
    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_xfer
            always_comb begin
                if (srst_d[g]) begin
                    xcnt_d[g] = 4'h0;                    // [R18]
                end else if (start_d[g]) begin
                    xcnt_d[g] = XFER_CYCLES;             // [R15]
                end else if (xcnt_q[g] != 4'h0) begin
                    xcnt_d[g] = xcnt_q[g] - 4'h1;
                end else begin
                    xcnt_d[g] = 4'h0;
                end
            end

            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    xcnt_q[g] <= 4'h0;
                end else begin
                    xcnt_q[g] <= xcnt_d[g];
                end
            end
        end
    endgenerate

    // register the state and the read answer
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sif_q        <= SIF_RST;
            act_q        <= '0;
            srst_q       <= '0;                          // [R17]
            bus.rdata    <= 8'h00;
            bus.rdata_oe <= 1'b0;
        end else begin
            sif_q        <= sif_d;
            act_q        <= act_d;
            srst_q       <= srst_d;
            bus.rdata    <= rdata_d;
            bus.rdata_oe <= rd_en;
        end
    end

    // -------------------------------------------------------------------------
    // registered outputs
    // -------------------------------------------------------------------------
    logic [2:0]          dev_adr;
    logic [NUM_CHAN-1:0] tip_d;

    assign dev_adr = sif_q[SIF_ADR_LSB +: 3];

    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            tip_d[i] = (xcnt_d[i] != 4'h0);
        end
    end

    // channel reset follows hardware reset too, so both look the same downstream
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cell_packet_mode_sel_o  <= 1'b0;
            packet_level_xfer_sel_o <= 1'b0;
            sys_bus_oe_o            <= 1'b0;
            pkt_avail_oe_o          <= 1'b0;
            tx_sel_o                <= 1'b0;
            tx_chan_o               <= 2'h0;
            rx_sel_o                <= 1'b0;
            rx_chan_o               <= 2'h0;
            irq_out_n_o             <= 1'b1;
            chan_reset_o            <= CHAN_RST_RST;     // [R18]
            counter_latch_o         <= '0;
            transfer_in_progress_o  <= '0;
        end else begin
            cell_packet_mode_sel_o  <= sif_d[SIF_MODE_BIT];                          // [R01] [R02]
            packet_level_xfer_sel_o <= sif_d[SIF_MODE_BIT] && sif_d[SIF_PLVL_BIT];   // [R03]
            sys_bus_oe_o            <= sif_d[SIF_EN_BIT];                            // [R04]
            pkt_avail_oe_o          <= 1'b1;                                         // [R04]
            tx_sel_o                <= sif_q[SIF_EN_BIT] && bus_hit(txa_s2_q, dev_adr); // [R07] [R08]
            tx_chan_o               <= txa_s2_q[1:0];                                // [R07]
            rx_sel_o                <= sif_q[SIF_EN_BIT] && bus_hit(rxa_s2_q, dev_adr); // [R07] [R08]
            rx_chan_o               <= rxa_s2_q[1:0];
            irq_out_n_o             <= !(|chan_irq_i || synth_irq_i);                // [R12]
            chan_reset_o            <= srst_d;                                       // [R17] [R18]
            counter_latch_o         <= start_d;                                      // [R15]
            transfer_in_progress_o  <= tip_d;                                        // [R15]
        end
    end
endmodule
`default_nettype wire

// ===== mcs_host_end.sv
// host end: sequences register accesses and polls the clock activity register
`default_nettype none
module mcs_host_end (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    // register port
    mcs_reg_if.host          bus,
    // user command port
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [10:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    output logic             busy_o,
    output logic             done_o,
    output logic [7:0]       rdata_o,
    // clocks with no edge since the previous activity read
    output logic [7:0]       clk_fail_o
);
    import mcs_pkg::*;

    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    // reserved and unused bits always go out at their defaults
    function automatic logic [7:0] clean(input logic [10:0] a, input logic [7:0] d);
        if (a == OFS_SIF) begin
            return d & SIF_WMASK & 8'hfb;                // [R20]
        end else if (a[7:0] == OFS_CRU) begin
            return d & CRU_WMASK;                        // [R20]
        end
        return d;
    endfunction

    // -------------------------------------------------------------------------
    // sequencer
    // -------------------------------------------------------------------------
    mcs_host_state_t st_q, st_d;
    logic        we_q, we_d, pend_q, pend_d, poll_q, poll_d;
    logic [10:0] addr_q, addr_d;
    logic [7:0]  data_q, data_d, shadow_q, shadow_d, rd_q, rd_d, fail_q, fail_d;
    logic [11:0] pcnt_q, pcnt_d;
    logic        done_d;

    always_comb begin
        st_d     = st_q;
        we_d     = we_q;
        pend_d   = pend_q;
        poll_d   = poll_q;
        addr_d   = addr_q;
        data_d   = data_q;
        shadow_d = shadow_q;
        rd_d     = rd_q;
        fail_d   = fail_q;
        done_d   = 1'b0;
        pcnt_d   = (pcnt_q == 12'h000) ? 12'h000 : pcnt_q - 12'h001;
        case (st_q)
            H_IDLE: begin
                if (req_i) begin
                    st_d   = H_STROBE;
                    we_d   = we_i;
                    poll_d = 1'b0;
                    addr_d = addr_i;
                    data_d = clean(addr_i, wdata_i);
                    pend_d = 1'b0;
                    // new device address goes in with the bus still off
                    if (we_i && addr_i == OFS_SIF && wdata_i[SIF_EN_BIT] &&
                        wdata_i[7:5] != shadow_q[7:5]) begin
                        data_d[SIF_EN_BIT] = 1'b0;       // [R06]
                        pend_d = 1'b1;
                    end
                end else if (pcnt_q == 12'h000) begin
                    st_d   = H_STROBE;                   // [R11]
                    we_d   = 1'b0;
                    poll_d = 1'b1;
                    addr_d = OFS_CKM;
                end
            end
            H_STROBE: begin
                st_d = H_WAIT;
                if (we_q && addr_q == OFS_SIF) begin
                    shadow_d = data_q;
                end
            end
            H_WAIT: begin
                if (pend_q) begin
                    st_d   = H_STROBE;                   // [R05] [R06]
                    pend_d = 1'b0;
                    data_d[SIF_EN_BIT] = 1'b1;
                end else begin
                    st_d   = H_IDLE;
                    done_d = !poll_q;
                    if (!we_q) begin
                        rd_d = bus.rdata;
                    end
                    if (!we_q && addr_q == OFS_CKM) begin
                        fail_d = ~bus.rdata;             // [R11]
                        pcnt_d = POLL_CYCLES;
                    end
                end
            end
            default: st_d = H_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_q     <= H_IDLE;
            we_q     <= 1'b0;
            pend_q   <= 1'b0;
            poll_q   <= 1'b0;
            addr_q   <= 11'h000;
            data_q   <= 8'h00;
            shadow_q <= SIF_RST;
            rd_q     <= 8'h00;
            fail_q   <= 8'h00;
            pcnt_q   <= POLL_CYCLES;
        end else begin
            st_q     <= st_d;
            we_q     <= we_d;
            pend_q   <= pend_d;
            poll_q   <= poll_d;
            addr_q   <= addr_d;
            data_q   <= data_d;
            shadow_q <= shadow_d;
            rd_q     <= rd_d;
            fail_q   <= fail_d;
            pcnt_q   <= pcnt_d;
        end
    end

    // -------------------------------------------------------------------------
    // registered pins and user outputs
    // -------------------------------------------------------------------------
    // strobes stand exactly the one cycle spent in H_STROBE
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            bus.cs_n   <= 1'b1;
            bus.rd_n   <= 1'b1;
            bus.wr_n   <= 1'b1;
            bus.addr   <= 11'h000;
            bus.wdata  <= 8'h00;
            busy_o     <= 1'b0;
            done_o     <= 1'b0;
            rdata_o    <= 8'h00;
            clk_fail_o <= 8'h00;
        end else begin
            bus.cs_n   <= (st_d != H_STROBE);
            bus.rd_n   <= !(st_d == H_STROBE && !we_d);
            bus.wr_n   <= !(st_d == H_STROBE && we_d);
            bus.addr   <= addr_d;
            bus.wdata  <= data_d;
            busy_o     <= (st_d != H_IDLE);
            done_o     <= done_d;
            rdata_o    <= rd_d;
            clk_fail_o <= fail_d;
        end
    end
endmodule
`default_nettype wire

// ===== mcs_assertions.sv
// concurrent checks on the register port and device pins
`default_nettype none
module mcs_assertions (
    // clock and reset
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    // register port
    input wire logic        cs_n,
    input wire logic        rd_n,
    input wire logic        wr_n,
    input wire logic [10:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        rdata_oe,
    // device pins
    input wire logic [3:0]  chan_irq_i,
    input wire logic        synth_irq_i,
    input wire logic        irq_out_n_o,
    input wire logic [4:0]  tx_bus_addr_i,
    input wire logic        tx_sel_o,
    input wire logic [3:0]  chan_reset_o,
    input wire logic [3:0]  counter_latch_o,
    input wire logic [3:0]  transfer_in_progress_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------
    // properties
    // --------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // channel 2 register write, seen only by its own address
    wire logic ch2_wr = !cs_n && !wr_n && addr == 11'h105;
    sequence rd_strobe; !cs_n && !rd_n && wr_n; endsequence
    sequence tip_run; transfer_in_progress_o[1] [*8] ##1 !transfer_in_progress_o[1]; endsequence
    rd_answer_a: assert property (rd_strobe |=> rdata_oe)
        else $error("read strobe got no data cycle");
    oe_cause_a: assert property (rdata_oe |-> $past(!cs_n && !rd_n && wr_n))
        else $error("read data driven without a strobe");
    irq_set_a: assert property ((|chan_irq_i || synth_irq_i) |=> !irq_out_n_o)
        else $error("interrupt output stayed high");
    irq_idle_a: assert property (!(|chan_irq_i || synth_irq_i) |=> irq_out_n_o)
        else $error("interrupt output low with no source");
    latch_start_a: assert property (ch2_wr && !wdata[7] |=> counter_latch_o[1])
        else $error("counter transfer not started");
    tip_len_a: assert property (counter_latch_o[1] |-> tip_run)
        else $error("transfer flag length wrong");
    srst_set_a: assert property (ch2_wr && wdata[7] |=> chan_reset_o[1])
        else $error("soft reset bit not set");
    // first edge after release still shows the reset value, so skip it
    srst_hold_a: assert property (chan_reset_o[1] && $past(rst_n_i) && !ch2_wr |=> chan_reset_o[1])
        else $error("soft reset cleared itself");
    null_addr_a: assert property ($past(tx_bus_addr_i, 3) == 5'h1f |-> !tx_sel_o)
        else $error("null address selected a port");
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench joining host end and device end
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------
    // stimulus and wiring
    // --------------------
    logic        mclk_i = 1'h0;
    logic        rst_n_i = 1'h0;
    logic        req_i = 1'h0;
    logic        we_i = 1'h0;
    logic [10:0] addr_i = 11'h000;
    logic [7:0]  wdata_i = 8'h00;
    logic [7:0]  mon_clk_i = 8'h00;
    logic [3:0]  chan_irq_i = 4'h0;
    logic        synth_irq_i = 1'h0;
    logic [4:0]  tx_bus_addr_i = 5'h00;
    logic [4:0]  rx_bus_addr_i = 5'h00;
    logic        done_o, cpm_o, plx_o, sys_bus_oe_o, pkt_avail_oe_o, tx_sel_o, rx_sel_o, irq_out_n_o, busy_o;
    logic [1:0]  tx_chan_o, rx_chan_o;
    logic [3:0]  chan_reset_o, counter_latch_o, tip_o;
    logic [7:0]  rdata_o, rv, fail_o;
    int          err_total = 0;
    int          checks = 0;
    always #12.5 mclk_i = ~mclk_i;
    mcs_reg_if bus_if ();
    mcs_dev_end mcs_dev_end_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(bus_if.dev), .mon_clk_i(mon_clk_i),
        .chan_irq_i(chan_irq_i), .synth_irq_i(synth_irq_i), .tx_bus_addr_i(tx_bus_addr_i),
        .rx_bus_addr_i(rx_bus_addr_i), .cell_packet_mode_sel_o(cpm_o), .packet_level_xfer_sel_o(plx_o),
        .sys_bus_oe_o(sys_bus_oe_o), .pkt_avail_oe_o(pkt_avail_oe_o), .tx_sel_o(tx_sel_o), .tx_chan_o(tx_chan_o),
        .rx_sel_o(rx_sel_o), .rx_chan_o(rx_chan_o), .irq_out_n_o(irq_out_n_o), .chan_reset_o(chan_reset_o),
        .counter_latch_o(counter_latch_o), .transfer_in_progress_o(tip_o));
    mcs_host_end mcs_host_end_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(bus_if.host), .req_i(req_i),
        .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o),
        .clk_fail_o(fail_o));
    mcs_assertions mcs_assertions_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n(bus_if.cs_n),
        .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .addr(bus_if.addr), .wdata(bus_if.wdata),
        .rdata_oe(bus_if.rdata_oe), .chan_irq_i(chan_irq_i), .synth_irq_i(synth_irq_i),
        .irq_out_n_o(irq_out_n_o), .tx_bus_addr_i(tx_bus_addr_i), .tx_sel_o(tx_sel_o),
        .chan_reset_o(chan_reset_o), .counter_latch_o(counter_latch_o), .transfer_in_progress_o(tip_o));
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one host access; done_o is a flop, so waiting at edges sees it race-free
    task automatic acc(input logic w, input logic [10:0] a, input logic [7:0] d);
        int n;
        req_i <= 1'h1;
        we_i <= w;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        req_i <= 1'h0;
        for (n = 0; n < 20 && done_o !== 1'h1; n++) @(posedge mclk_i);
        if (n == 20) begin
            err_total++;
            conclude();
        end
        rv = rdata_o;
        chk("busy", {7'h00, busy_o}, 8'h00);
    endtask
    task automatic t_sif();
        acc(0, 11'h002, 8'h00); chk("sif reset", rv, 8'h00);
        acc(1, 11'h002, 8'h33);
        acc(0, 11'h002, 8'h00); chk("sif readback", rv, 8'h33);
        chk("mode pins", {5'h00, sys_bus_oe_o, plx_o, cpm_o}, 8'h07);
        tx_bus_addr_i <= 5'h06;
        rx_bus_addr_i <= 5'h05;
        repeat (4) @(posedge mclk_i);
        chk("select", {2'h0, tx_sel_o, tx_chan_o, rx_sel_o, rx_chan_o}, 8'h35);
        tx_bus_addr_i <= 5'h1f;
        repeat (4) @(posedge mclk_i);
        chk("null select", {6'h00, tx_sel_o, rx_sel_o}, 8'h01);
        acc(1, 11'h002, 8'h22);
        chk("disabled", {4'h0, pkt_avail_oe_o, sys_bus_oe_o, plx_o, rx_sel_o}, 8'h08);
        acc(1, 11'h002, 8'h33);
        $display("t_sif done");
    endtask
    task automatic t_mon(input logic [7:0] p);
        repeat (3) begin
            mon_clk_i <= p;
            repeat (3) @(posedge mclk_i);
            mon_clk_i <= 8'h00;
            repeat (3) @(posedge mclk_i);
        end
        repeat (4) @(posedge mclk_i);
        acc(0, 11'h003, 8'h00); chk("activity", rv, p);
        acc(0, 11'h003, 8'h00); chk("activity cleared", rv, 8'h00);
        chan_irq_i <= p[3:0];
        synth_irq_i <= p[4];
        acc(0, 11'h004, 8'h00); chk("summary", rv, {3'h0, p[4:0]});
        acc(0, 11'h004, 8'h00); chk("summary kept", rv, {3'h0, p[4:0]});
        chk("irq pin", {7'h00, irq_out_n_o}, 8'h00);
        chan_irq_i <= 4'h0;
        synth_irq_i <= 1'h0;
        $display("t_mon done");
    endtask
    task automatic t_cru();
        acc(1, 11'h105, 8'h00);
        acc(0, 11'h105, 8'h00); chk("tip busy", rv & 8'h81, 8'h01);
        repeat (8) @(posedge mclk_i);
        acc(0, 11'h105, 8'h00); chk("tip done", rv & 8'h81, 8'h00);
        acc(1, 11'h105, 8'h80); chk("ch2 reset", {4'h0, chan_reset_o}, 8'h02);
        repeat (20) @(posedge mclk_i);
        acc(0, 11'h105, 8'h00); chk("ch2 held", rv & 8'h81, 8'h80);
        acc(0, 11'h002, 8'h00); chk("glob open", rv, 8'h33);
        acc(1, 11'h005, 8'h80);
        acc(0, 11'h002, 8'h00); chk("glob blocked", rv, 8'h00);
        acc(1, 11'h002, 8'h00);
        acc(1, 11'h005, 8'h00);
        acc(0, 11'h002, 8'h00); chk("glob kept", rv, 8'h33);
        rst_n_i <= 1'h0;
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'h1;
        repeat (2) @(posedge mclk_i);
        chk("hw clears", {4'h0, chan_reset_o}, 8'h00);
        $display("t_cru done");
    endtask
    // one rising edge after reset, then the host's own periodic poll must flag the quiet clocks
    task automatic t_poll();
        mon_clk_i <= 8'h3c;
        repeat (4010) @(posedge mclk_i);
        chk("poll fail", fail_o, 8'hc3);
        $display("t_poll done");
    endtask
    initial begin
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'h1;
        @(posedge mclk_i);
        t_sif();
        t_mon(8'h5a);
        t_mon(8'ha5);
        t_cru();
        t_poll();
        conclude();
    end
endmodule
`default_nettype wire
